// ### lsc_pkg.sv
// Shared constants for the link sideband control block
package lsc_pkg;
    // Reference clock and link timing
    localparam int REF_MHZ = 20;
    localparam int LINK_TIMEOUT_NS = 1000;
    localparam int LINK_TIMEOUT_CYC = (LINK_TIMEOUT_NS * REF_MHZ + 999) / 1000;
    localparam logic [7:0] LOCK_SYMBOLS = 8'h08;
    // Forward symbol layout
    localparam int PAYLOAD_W = 35;
    localparam int FIFO_DEPTH = 8;
    localparam int PL_GPIO_LSB = 24;
    localparam int PL_PASS = 28;
    localparam int PL_C18 = 29;
    localparam int PL_DGPIO_LSB = 30;
    // Pixel clock windows in MHz
    localparam logic [7:0] PCLK1_MIN = 8'h19;
    localparam logic [7:0] PCLK1_MAX = 8'h60;
    localparam logic [7:0] PCLK2_MIN = 8'h32;
    localparam logic [7:0] PCLK2_MAX = 8'hAA;
    // GPIO nibble codes
    localparam logic [3:0] GPIO_FWD_OUT = 4'h5;
    localparam logic [3:0] GPIO_BC_IN = 4'h3;
    localparam logic [3:0] GPIO_LOCAL_LO = 4'h1;
    localparam logic [3:0] GPIO_LOCAL_HI = 4'h9;
    localparam logic [15:0] GPIO_CFG_RST = 16'h0000;
    // Back channel dividers and sampling modes
    localparam logic [2:0] BC_DIV_SLOW = 3'h4;
    localparam logic [2:0] BC_DIV_MID = 3'h2;
    localparam logic [2:0] BC_DIV_FAST = 3'h1;
    localparam logic [2:0] HSCC_FAST1 = 3'h1;
    localparam logic [2:0] HSCC_FAST2 = 3'h2;
    // Synchronised pin positions
    localparam int NPIN = 12;
    localparam int PIN_PD = 0;
    localparam int PIN_LCLK = 1;
    localparam int PIN_IRQ = 2;
    localparam int PIN_STRAP = 3;
    localparam int PIN_GPIO = 4;
    localparam int PIN_DGPIO = 8;
    typedef enum logic [1:0] {LSC_OFF, LSC_LOCKING, LSC_LOCKED} lsc_state_e;
endpackage

// ### lsc_ctrl.sv
// Sideband control: port select, lock and output state, irq relay, GPIO, back channel rate
`timescale 1ns/1ps
`default_nettype none

module lsc_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic push, pop;

    always_comb begin
        in_ready = (wp_r - rp_r) != (AW + 1)'(DEPTH);
        out_valid = wp_r != rp_r;
        out_data = mem[rp_r[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_nxt = wp_r + (AW + 1)'(push);
        rp_nxt = rp_r + (AW + 1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule // lsc_fifo

module lsc_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Pins from outside the clock domain
    input wire logic power_down_n,
    input wire logic link_clk,
    input wire logic [lsc_pkg::PAYLOAD_W-1:0] link_data,
    input wire logic irq_in_n,
    input wire logic strap_mode_pin,
    input wire logic [3:0] gpio_in,
    input wire logic [3:0] dgpio_in,
    // Configuration
    input wire logic [1:0] port_select,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wr_data,
    input wire logic output_enable,
    input wire logic sleep_select,
    input wire logic irq_fwd_en,
    input wire logic two_lane,
    input wire logic div_select,
    input wire logic fast_backchan_en,
    input wire logic [2:0] hscc_mode,
    input wire logic [7:0] pclk_mhz,
    input wire logic video_ready,
    // Status
    output logic [15:0] cfg_rd_data,
    output logic [3:0] gpio_level,
    output logic [3:0] dgpio_level,
    output logic pclk_ok,
    output logic color18,
    output logic fifo_overflow,
    // Lock and pass pins
    output logic lock_out,
    output logic lock_oe_n,
    output logic pass_out,
    output logic pass_oe_n,
    // Video output
    output logic [lsc_pkg::PAYLOAD_W-1:0] video_data,
    output logic video_valid,
    output logic data_oe_n,
    output logic csi_hs0,
    output logic csi_oe_n,
    // GPIO pins
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe_n,
    output logic [3:0] dgpio_out,
    output logic [3:0] dgpio_oe_n,
    // Back channel
    output logic bc_tick,
    output logic [2:0] bc_div,
    output logic [3:0] bc_gpio,
    output logic [3:0] bc_dgpio,
    output logic bc_irq_n
);
    import lsc_pkg::*;

    // Returns {drive, value} for one pin nibble
    function automatic logic [1:0] pin_drive(input logic [3:0] code, input logic fwd, input logic ok);
        if (code == GPIO_FWD_OUT) begin
            return {1'b1, fwd & ok};
        end else if (code == GPIO_LOCAL_LO) begin
            return 2'b10;
        end else if (code == GPIO_LOCAL_HI) begin
            return {1'b1, ok};
        end else begin
            return 2'b00;
        end
    endfunction

    // Three-stage pin synchronisers
    logic [NPIN-1:0] s1_r, s2_r, s3_r, st_r, st_nxt;
    logic [NPIN-1:0] pins;
    assign pins = {dgpio_in, gpio_in, strap_mode_pin, irq_in_n, link_clk, power_down_n};
    assign st_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & st_r);
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            st_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            st_r <= st_nxt;
        end
    end

    logic pd_on, lclk_edge, link_active;
    logic lclk_prev_r;
    assign pd_on = st_r[PIN_PD];
    assign lclk_edge = st_r[PIN_LCLK] && !lclk_prev_r;

    // Lock state machine
    lsc_state_e state_r, state_nxt;
    logic [7:0] lock_cnt_r, lock_cnt_nxt;
    logic [7:0] idle_cnt_r, idle_cnt_nxt;
    logic strap_r, strap_nxt;
    assign link_active = idle_cnt_r < 8'(LINK_TIMEOUT_CYC);

    always_comb begin
        state_nxt = state_r;
        lock_cnt_nxt = lock_cnt_r;
        strap_nxt = strap_r;
        idle_cnt_nxt = lclk_edge ? 8'h00 : (link_active ? idle_cnt_r + 8'h01 : idle_cnt_r);
        if (!pd_on) begin
            state_nxt = LSC_OFF;
            lock_cnt_nxt = 8'h00;
        end else begin
            case (state_r)
                LSC_OFF: begin
                    // Strap caught as the device leaves power-down
                    strap_nxt = st_r[PIN_STRAP];
                    state_nxt = LSC_LOCKING;
                end
                LSC_LOCKING: begin
                    if (!link_active) begin
                        lock_cnt_nxt = 8'h00;
                    end else if (lclk_edge) begin
                        lock_cnt_nxt = lock_cnt_r + 8'h01;
                        if (lock_cnt_r == LOCK_SYMBOLS - 8'h01) begin
                            state_nxt = LSC_LOCKED;
                        end
                    end
                end
                default: begin
                    if (!link_active) begin
                        state_nxt = LSC_LOCKING;
                        lock_cnt_nxt = 8'h00;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= LSC_OFF;
            lock_cnt_r <= 8'h00;
            idle_cnt_r <= 8'hFF;
            strap_r <= 1'b0;
            lclk_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            strap_r <= strap_nxt;
            lclk_prev_r <= st_r[PIN_LCLK];
        end
    end

    // Symbol buffer; a full buffer drops the symbol and flags it
    logic locked, fifo_in_ready, fifo_out_valid, pop, push_req;
    logic [PAYLOAD_W-1:0] fifo_word;
    assign locked = state_r == LSC_LOCKED;
    assign push_req = lclk_edge && locked;
    assign pop = fifo_out_valid && video_ready;

    lsc_fifo #(.WIDTH(PAYLOAD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(push_req),
        .in_ready(fifo_in_ready),
        .in_data(link_data),
        .out_valid(fifo_out_valid),
        .out_ready(video_ready),
        .out_data(fifo_word)
    );

    // Per-port duplicated GPIO configuration
    logic [15:0] cfg_r [2];
    logic [15:0] cfg_nxt [2];
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign cfg_nxt[p] = (cfg_wr && port_select[p]) ? cfg_wr_data : cfg_r[p];
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                cfg_r[p] <= GPIO_CFG_RST;
            end else begin
                cfg_r[p] <= cfg_nxt[p];
            end
        end
    end

    // Output stage
    logic [PAYLOAD_W-1:0] held_r, held_nxt;
    logic [3:0] dmask;
    logic z_out, ok;
    logic [1:0] drv;
    logic [2:0] bc_cnt_r, bc_cnt_nxt, div_nxt;
    logic tick_nxt;
    logic [49:0] o_r, o_nxt;

    always_comb begin
        held_nxt = pop ? fifo_word : held_r;
        z_out = !pd_on || (!output_enable && sleep_select);
        ok = output_enable && sleep_select && locked;
        o_nxt = '0;
        // Reads favour port one when both selects are set
        o_nxt[15:0] = port_select[1] ? cfg_r[1] : (port_select[0] ? cfg_r[0] : 16'h0000);
        // Lock drops with power so it never reads high while released
        o_nxt[16] = locked && pd_on;
        o_nxt[17] = !pd_on || (!output_enable && !locked);
        if (ok) begin
            o_nxt[18] = held_nxt[PL_PASS];
        end else if (output_enable && sleep_select) begin
            o_nxt[18] = pass_out;
        end
        o_nxt[19] = z_out;
        o_nxt[20] = ok && pop;
        o_nxt[21] = z_out;
        o_nxt[22] = !ok;
        o_nxt[23] = held_nxt[PL_C18];
        o_nxt[24] = fifo_overflow || (push_req && !fifo_in_ready);
        if (!pd_on) begin
            o_nxt[24] = 1'b0;
        end
        o_nxt[25] = two_lane ? (pclk_mhz >= PCLK2_MIN && pclk_mhz <= PCLK2_MAX)
                             : (pclk_mhz >= PCLK1_MIN && pclk_mhz <= PCLK1_MAX);
        dmask = (hscc_mode == HSCC_FAST1) ? 4'h1 : ((hscc_mode == HSCC_FAST2) ? 4'h3 : 4'hF);
        for (int i = 0; i < 4; i++) begin
            // Port zero config drives GPIO pins, port one the fast pins
            drv = pin_drive(cfg_r[0][4*i+:4], held_nxt[PL_GPIO_LSB+i], ok);
            o_nxt[26+i] = drv[0];
            o_nxt[30+i] = z_out || !drv[1];
            drv = pin_drive(cfg_r[1][4*i+:4], held_nxt[PL_DGPIO_LSB+i], ok);
            o_nxt[34+i] = drv[0] && two_lane;
            o_nxt[38+i] = z_out || !drv[1] || !two_lane;
            o_nxt[42+i] = (cfg_r[0][4*i+:4] == GPIO_BC_IN) && st_r[PIN_GPIO+i];
            o_nxt[46+i] = (cfg_r[1][4*i+:4] == GPIO_BC_IN) && st_r[PIN_DGPIO+i]
                          && two_lane && dmask[i];
        end
        // Fast enable or strap beats the divider bit
        div_nxt = (fast_backchan_en || strap_r) ? BC_DIV_FAST : (div_select ? BC_DIV_MID : BC_DIV_SLOW);
        tick_nxt = pd_on && (bc_cnt_r >= div_nxt - 3'h1);
        bc_cnt_nxt = tick_nxt || !pd_on ? 3'h0 : bc_cnt_r + 3'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            held_r <= '0;
            o_r <= '0;
            lock_oe_n <= 1'b1;
            pass_oe_n <= 1'b1;
            data_oe_n <= 1'b1;
            csi_oe_n <= 1'b1;
            gpio_oe_n <= 4'hF;
            dgpio_oe_n <= 4'hF;
            video_data <= '0;
            bc_cnt_r <= 3'h0;
            bc_tick <= 1'b0;
            bc_div <= BC_DIV_SLOW;
            bc_gpio <= 4'h0;
            bc_dgpio <= 4'h0;
            bc_irq_n <= 1'b1;
            gpio_level <= 4'h0;
            dgpio_level <= 4'h0;
        end else begin
            held_r <= held_nxt;
            o_r <= o_nxt;
            lock_oe_n <= o_nxt[17];
            pass_oe_n <= o_nxt[19];
            data_oe_n <= o_nxt[21];
            csi_oe_n <= o_nxt[21];
            gpio_oe_n <= o_nxt[33:30];
            dgpio_oe_n <= o_nxt[41:38];
            video_data <= ok ? held_nxt : '0;
            bc_cnt_r <= bc_cnt_nxt;
            bc_tick <= tick_nxt;
            bc_div <= div_nxt;
            gpio_level <= st_r[PIN_GPIO+:4];
            dgpio_level <= st_r[PIN_DGPIO+:4];
            // Back channel frame contents change only on a frame tick, except bc_irq_n, which also clears in power-down
            if (tick_nxt) begin
                bc_gpio <= o_nxt[45:42];
                bc_dgpio <= o_nxt[49:46];
                bc_irq_n <= !(irq_fwd_en && !st_r[PIN_IRQ]);
            end
            if (!pd_on) begin
                bc_irq_n <= 1'b1;
            end
        end
    end

    assign cfg_rd_data = o_r[15:0];
    assign lock_out = o_r[16];
    assign pass_out = o_r[18];
    assign video_valid = o_r[20];
    assign csi_hs0 = o_r[22];
    assign color18 = o_r[23];
    assign fifo_overflow = o_r[24];
    assign pclk_ok = o_r[25];
    assign gpio_out = o_r[29:26];
    assign dgpio_out = o_r[37:34];
endmodule // lsc_ctrl

`default_nettype wire

// ### lsc_ctrl_chk.sv
// Port checker for lsc_ctrl
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_chk import lsc_pkg::*; (
    // Clock, reset, controls
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic irq_in_n,
    input wire logic [1:0] port_select,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wr_data,
    input wire logic output_enable,
    input wire logic irq_fwd_en,
    input wire logic two_lane,
    input wire logic div_select,
    input wire logic fast_backchan_en,
    // Outputs watched
    input wire logic [15:0] cfg_rd_data,
    input wire logic lock_out,
    input wire logic lock_oe_n,
    input wire logic pass_oe_n,
    input wire logic data_oe_n,
    input wire logic csi_oe_n,
    input wire logic csi_hs0,
    input wire logic video_valid,
    input wire logic [3:0] dgpio_oe_n,
    input wire logic bc_tick,
    input wire logic [2:0] bc_div,
    input wire logic bc_irq_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr_both;
        cfg_wr && port_select == 2'h3 ##1 (!cfg_wr && port_select == 2'h3) [*2];
    endsequence
    sequence s_irq_low;
        (irq_fwd_en && !irq_in_n) [*6] ##0 bc_tick;
    endsequence
    chk_pd_hiz: assert property (!power_down_n [*6] |-> lock_oe_n && pass_oe_n && data_oe_n && csi_oe_n)
        else $error("outputs driven in power down");
    chk_wr_both: assert property (s_wr_both |-> cfg_rd_data == $past(cfg_wr_data, 2))
        else $error("dual write not read back");
    chk_sel_none: assert property (port_select == 2'h0 [*2] |-> cfg_rd_data == 16'h0000)
        else $error("read without port select");
    chk_lock_drv: assert property ((power_down_n && output_enable) [*8] |-> !lock_oe_n)
        else $error("lock not driven");
    chk_lock_high: assert property (lock_out |-> !lock_oe_n)
        else $error("lock high but released");
    chk_div_rate: assert property ((!fast_backchan_en && $stable(div_select)) [*3] ##0 bc_div != BC_DIV_FAST
        |-> bc_div == (div_select ? BC_DIV_MID : BC_DIV_SLOW))
        else $error("back channel divider wrong");
    chk_lane_gate: assert property (!two_lane [*3] |-> &dgpio_oe_n)
        else $error("fast gpio driven on one lane");
    chk_video_gate: assert property (video_valid |-> !data_oe_n && !csi_hs0 && !csi_oe_n)
        else $error("video valid while gated");
    chk_irq_fwd: assert property (s_irq_low |=> !bc_irq_n)
        else $error("irq not relayed");
    chk_irq_off: assert property (!irq_fwd_en [*3] ##0 bc_tick |=> bc_irq_n)
        else $error("irq relayed while disabled");
endmodule // lsc_ctrl_chk
`default_nettype wire

// ### lsc_ser_model.sv
// Serializer-side model: forward symbols and remote irq pin
`timescale 1ns/1ps
`default_nettype none
module lsc_ser_model (
    // Bench control
    input wire logic run,
    input wire logic [34:0] base,
    input wire logic status_rd,
    // Forward link
    output logic link_clk,
    output logic [34:0] link_data,
    // Back channel
    input wire logic ref_clk,
    input wire logic bc_tick,
    input wire logic bc_irq_n,
    output logic remote_irq_out_n
);
    logic [34:0] k;
    logic prev_n;
    initial begin
        link_clk = 1'b0;
        link_data = 35'h0;
        remote_irq_out_n = 1'b1;
        prev_n = 1'b1;
        k = 35'h0;
        forever begin
            if (run) begin
                link_data = base + k;
                k = k + 35'h1;
                #200 link_clk = 1'b1;
                #200 link_clk = 1'b0;
            end else begin
                // Clock still; data churns so stale bits are never trusted
                link_data = ~link_data;
                k = 35'h0;
                #50;
            end
        end
    end
    always @(posedge ref_clk) begin
        if (bc_tick) begin
            if (!bc_irq_n && prev_n) remote_irq_out_n <= 1'b0;
            prev_n <= bc_irq_n;
        end
        if (status_rd) remote_irq_out_n <= 1'b1;
    end
endmodule // lsc_ser_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for lsc_ctrl
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lsc_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, power_down_n = 1'b0, irq_in_n = 1'b1, strap_mode_pin = 1'b0;
    logic cfg_wr = 1'b0, output_enable = 1'b0, sleep_select = 1'b0, irq_fwd_en = 1'b0, two_lane = 1'b0;
    logic div_select = 1'b0, fast_backchan_en = 1'b0, video_ready = 1'b0, run = 1'b0, status_rd = 1'b0;
    logic [3:0] gpio_in = 4'hA, dgpio_in = 4'hF, gpio_level, dgpio_level, gpio_out, gpio_oe_n;
    logic [3:0] dgpio_out, dgpio_oe_n, bc_gpio, bc_dgpio;
    logic [1:0] port_select = 2'h0;
    logic [15:0] cfg_wr_data = 16'h0000, cfg_rd_data;
    logic [2:0] hscc_mode = 3'h0, bc_div;
    logic [7:0] pclk_mhz = 8'h00;
    logic [34:0] base = 35'h17A000000, link_data, video_data;
    logic link_clk, pclk_ok, color18, fifo_overflow, lock_out, lock_oe_n, pass_out, pass_oe_n;
    logic video_valid, data_oe_n, csi_hs0, csi_oe_n, bc_tick, bc_irq_n, remote_irq_out_n;
    int num_errors = 0, n_tests = 0;
    logic [34:0] got [$];
    localparam logic [9:0] PTAB [8] = '{10'h018, 10'h219, 10'h260, 10'h061, 10'h131, 10'h332, 10'h3AA, 10'h1AB};
    localparam logic [6:0] HTAB [3] = '{7'h11, 7'h23, 7'h0F};
    always #25 ref_clk = ~ref_clk;
    lsc_ctrl uut (.*);
    lsc_ser_model ser (.*);
    always @(negedge ref_clk) if (video_valid === 1'b1) got.push_back(video_data);
    task automatic wrap_up;
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic ck(input string nm, input logic [34:0] e, input logic [34:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wait_hi(ref logic s, input int n);
        int i;
        for (i = 0; i < n && s !== 1'b1; i++) w(1);
        if (i == n) begin
            num_errors++;
            $display("unexpected wait: expected 1 seen %b", s);
            wrap_up();
        end
    endtask
    task automatic wr(input logic [1:0] ps, input logic [15:0] d);
        port_select = ps;
        cfg_wr_data = d;
        cfg_wr = 1'b1;
        w(1);
        cfg_wr = 1'b0;
        w(1);
    endtask
    task automatic rd(input logic [1:0] ps, input logic [15:0] e);
        port_select = ps;
        w(3);
        ck("cfg_rd_data", e, cfg_rd_data);
    endtask
    task automatic t_pclk;
        for (int i = 0; i < 8; i++) begin
            {two_lane, pclk_mhz} = PTAB[i][8:0];
            w(3);
            ck("pclk_ok", PTAB[i][9], pclk_ok);
        end
    endtask
    task automatic t_lock;
        output_enable = 1'b1;
        sleep_select = 1'b1;
        power_down_n = 1'b1;
        w(8);
        run = 1'b1;
        w(55);
        ck("lock_out", 0, lock_out);
        ck("lock_oe_n", 0, lock_oe_n);
        wait_hi(lock_out, 40);
        power_down_n = 1'b0;
        w(6);
        ck("lock_oe_n", 1, lock_oe_n);
        ck("csi_oe_n", 1, csi_oe_n);
        power_down_n = 1'b1;
        w(10);
        ck("lock_out", 0, lock_out);
        wait_hi(lock_out, 80);
    endtask
    task automatic t_cfg;
        wr(2'h3, 16'h5555);
        rd(2'h3, 16'h5555);
        wr(2'h1, 16'h3159);
        rd(2'h1, 16'h3159);
        rd(2'h2, 16'h5555);
        rd(2'h3, 16'h5555);
        rd(2'h0, 16'h0000);
        ck("gpio_oe_n", 4'h8, gpio_oe_n);
        ck("gpio_level", 4'hA, gpio_level);
        ck("gpio_out", 4'h1, gpio_out);
        ck("dgpio_level", 4'hF, dgpio_level);
        two_lane = 1'b0;
        w(3);
        ck("dgpio_oe_n", 4'hF, dgpio_oe_n);
        two_lane = 1'b1;
        w(3);
        ck("dgpio_oe_n", 4'h0, dgpio_oe_n);
    endtask
    task automatic t_out;
        sleep_select = 1'b0;
        w(3);
        ck("csi_hs0", 1, csi_hs0);
        ck("pass_out", 0, pass_out);
        output_enable = 1'b0;
        sleep_select = 1'b1;
        w(3);
        ck("data_oe_n", 1, data_oe_n);
        ck("gpio_oe_n", 4'hF, gpio_oe_n);
        output_enable = 1'b1;
    endtask
    task automatic t_fifo;
        got.delete();
        wait_hi(fifo_overflow, 200);
        video_ready = 1'b1;
        w(200);
        // A stalled drain must drop, so a hole follows the eighth word
        for (int i = 1; i < 8; i++) ck("video_data", got[i-1] + 35'h1, got[i]);
        ck("dropped", 1, got[8] > got[7] + 35'h1);
        ck("pass_out", 1, pass_out);
        ck("color18", 1, color18);
        ck("gpio_out", 4'h3, gpio_out);
        ck("dgpio_out", 4'h5, dgpio_out);
    endtask
    task automatic t_bc;
        int nt;
        {fast_backchan_en, div_select} = 2'b01;
        w(4);
        ck("bc_div", BC_DIV_MID, bc_div);
        {fast_backchan_en, div_select} = 2'b11;
        w(4);
        ck("bc_div", BC_DIV_FAST, bc_div);
        {fast_backchan_en, div_select} = 2'b00;
        w(4);
        ck("bc_div", BC_DIV_SLOW, bc_div);
        nt = 0;
        repeat (8) begin
            w(1);
            if (bc_tick === 1'b1) nt++;
        end
        ck("bc_tick", 2, nt);
        wr(2'h2, 16'h3333);
        for (int i = 0; i < 3; i++) begin
            hscc_mode = HTAB[i][6:4];
            w(12);
            ck("bc_dgpio", HTAB[i][3:0], bc_dgpio);
        end
        ck("bc_gpio", 4'h8, bc_gpio);
        // Strap is only taken as power-down releases
        strap_mode_pin = 1'b1;
        power_down_n = 1'b0;
        w(6);
        power_down_n = 1'b1;
        w(8);
        ck("bc_div", BC_DIV_FAST, bc_div);
    endtask
    task automatic t_irq;
        irq_fwd_en = 1'b1;
        irq_in_n = 1'b0;
        w(14);
        ck("bc_irq_n", 0, bc_irq_n);
        ck("remote_irq_out_n", 0, remote_irq_out_n);
        status_rd = 1'b1;
        w(1);
        status_rd = 1'b0;
        irq_fwd_en = 1'b0;
        w(14);
        ck("bc_irq_n", 1, bc_irq_n);
        ck("remote_irq_out_n", 1, remote_irq_out_n);
    endtask
    initial begin
        w(10);
        reset_n = 1'b1;
        w(2);
        ck("data_oe_n", 1, data_oe_n);
        t_pclk();
        t_lock();
        t_cfg();
        t_out();
        t_fifo();
        t_bc();
        t_irq();
        wrap_up();
    end
endmodule // tb
bind lsc_ctrl lsc_ctrl_chk chk (.*);
`default_nettype wire
